// File: logic/dpa_adapter.sv
// Dual peripheral port adapter: ports, read-back paths and interrupt requests
`default_nettype none

// What this block does
// - Two 8-bit two-way ports, each side with two control lines.
// - Direction bit 1 makes a line an output, 0 an input.
// - Port A output lines drive their out-latch bit.
// - Port A input lines ignore the out latch.
// - Port A data read with access bit set returns all sampled pins.
// - Port A output lines read back the pin, not the latch.
// - Port B read: latch for outputs, pin for inputs.
// - Port B input lines are not driven.
// - Reset clears every internal register to zero.
// - Request outputs are active low and only pull low.
// - Bits 6 and 7 of each control register are flags with enables.
// - Side A bit 7 set by each active edge on line one.
// - Side A bit 6 set by active edge on line two when input.
// - Reading port A data clears side A flags.
// - Side B flags set like side A, enables bits 0 and 3.
// - Reading port B data clears side B flags.
// - Request low when bit7 and bit0, or bit6 and bit3, are set.
// - Access bit 1 selects port location, 0 selects direction register.
// - Bit 1 picks line one edge: 0 falling, 1 rising.
// - Bit 4 picks line two edge while line two is an input.
module dpa_adapter (
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  input  wire logic                       select_high_first_in,
  input  wire logic                       select_high_second_in,
  input  wire logic                       select_low_in,
  input  wire logic                       reg_select_hi_in,
  input  wire logic                       reg_select_lo_in,
  input  wire logic [7:0]                 wr_data_in,
  input  wire logic                       wr_strobe_in,
  input  wire logic                       rd_strobe_in,
  output logic      [7:0]                 rd_data_out,
  input  wire logic [dpa_pkg::PORT_W-1:0] port_a_pins_in,
  output logic      [dpa_pkg::PORT_W-1:0] port_a_pins_out,
  output logic      [dpa_pkg::PORT_W-1:0] port_a_pins_oe_out,
  input  wire logic [dpa_pkg::PORT_W-1:0] port_b_pins_in,
  output logic      [dpa_pkg::PORT_W-1:0] port_b_pins_out,
  output logic      [dpa_pkg::PORT_W-1:0] port_b_pins_oe_out,
  input  wire logic                       side_a_irq_input_in,
  input  wire logic                       side_a_ctl_line_in,
  input  wire logic                       side_b_irq_input_in,
  input  wire logic                       side_b_ctl_line_in,
  output logic                            side_a_req_n_out,
  output logic                            side_a_req_oe_out,
  output logic                            side_b_req_n_out,
  output logic                            side_b_req_oe_out
);
  import dpa_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CTL_W-1:0]  side_a_control_reg;
    logic [CTL_W-1:0]  side_b_control_reg;
    logic [PORT_W-1:0] port_a_direction;
    logic [PORT_W-1:0] port_b_direction;
    logic [PORT_W-1:0] port_a_out_latch;
    logic [PORT_W-1:0] port_b_out_latch;
    logic [7:0]        rd_data;
    logic [PORT_W-1:0] pa_out;
    logic [PORT_W-1:0] pa_oe;
    logic [PORT_W-1:0] pb_out;
    logic [PORT_W-1:0] pb_oe;
    logic              req_a;
    logic              req_b;
  } dpa_state_type;

  dpa_state_type st_q;
  dpa_state_type st_d;

  logic [PORT_W-1:0] pa_level;
  logic [PORT_W-1:0] pb_level;
  logic [3:0]        ctl_level;
  logic              selected;
  logic [1:0]        addr;
  logic              rd_port_a;
  logic              rd_port_b;
  logic              evt_a1;
  logic              evt_a2;
  logic              evt_b1;
  logic              evt_b2;
  logic              flag_a1;
  logic              flag_a2;
  logic              flag_b1;
  logic              flag_b2;
  logic [7:0]        ctl_a_view;
  logic [7:0]        ctl_b_view;
  logic [PORT_W-1:0] pb_view;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  dpa_pin_sync #(.W(PORT_W)) u_sync_pa (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .raw_in    (port_a_pins_in),
    .level_out (pa_level)
  );

  dpa_pin_sync #(.W(PORT_W)) u_sync_pb (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .raw_in    (port_b_pins_in),
    .level_out (pb_level)
  );

  dpa_pin_sync #(.W(4)) u_sync_ctl (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .raw_in    ({side_b_ctl_line_in, side_b_irq_input_in,
                 side_a_ctl_line_in, side_a_irq_input_in}),
    .level_out (ctl_level)
  );

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign selected  = select_high_first_in & select_high_second_in & ~select_low_in;
  assign addr      = {reg_select_hi_in, reg_select_lo_in};
  assign rd_port_a = rd_strobe_in & selected & (addr == ADDR_PORT_A)
                   & st_q.side_a_control_reg[BIT_ACCESS];
  assign rd_port_b = rd_strobe_in & selected & (addr == ADDR_PORT_B)
                   & st_q.side_b_control_reg[BIT_ACCESS];

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  dpa_side_flags u_flags_a (
    .clock_in          (clock_in),
    .rst_in            (rst_in),
    .line1_in          (ctl_level[0]),
    .line2_in          (ctl_level[1]),
    .edge1_rise_in     (st_q.side_a_control_reg[BIT_L1_EDGE]),
    .edge2_rise_in     (st_q.side_a_control_reg[BIT_L2_EDGE]),
    .line2_is_input_in (~st_q.side_a_control_reg[BIT_L2_OUT]),
    .clear_in          (rd_port_a),
    .evt1_out          (evt_a1),
    .evt2_out          (evt_a2),
    .flag1_out         (flag_a1),
    .flag2_out         (flag_a2)
  );

  dpa_side_flags u_flags_b (
    .clock_in          (clock_in),
    .rst_in            (rst_in),
    .line1_in          (ctl_level[2]),
    .line2_in          (ctl_level[3]),
    .edge1_rise_in     (st_q.side_b_control_reg[BIT_L1_EDGE]),
    .edge2_rise_in     (st_q.side_b_control_reg[BIT_L2_EDGE]),
    .line2_is_input_in (~st_q.side_b_control_reg[BIT_L2_OUT]),
    .clear_in          (rd_port_b),
    .evt1_out          (evt_b1),
    .evt2_out          (evt_b2),
    .flag1_out         (flag_b1),
    .flag2_out         (flag_b2)
  );

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  assign ctl_a_view = dpa_ctl_view(flag_a1, flag_a2, st_q.side_a_control_reg);
  assign ctl_b_view = dpa_ctl_view(flag_b1, flag_b2, st_q.side_b_control_reg);
  assign pb_view    = (st_q.port_b_out_latch & st_q.port_b_direction)
                    | (pb_level & ~st_q.port_b_direction);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Write path
    if (wr_strobe_in && selected) begin
      case (addr)
        ADDR_PORT_A: begin
          if (st_q.side_a_control_reg[BIT_ACCESS]) begin
            st_d.port_a_out_latch = wr_data_in;
          end else begin
            st_d.port_a_direction = wr_data_in;
          end
        end
        ADDR_CTL_A: begin
          st_d.side_a_control_reg = wr_data_in[CTL_W-1:0];
        end
        ADDR_PORT_B: begin
          if (st_q.side_b_control_reg[BIT_ACCESS]) begin
            st_d.port_b_out_latch = wr_data_in;
          end else begin
            st_d.port_b_direction = wr_data_in;
          end
        end
        ADDR_CTL_B: begin
          st_d.side_b_control_reg = wr_data_in[CTL_W-1:0];
        end
        default: begin
          st_d.side_a_control_reg = st_q.side_a_control_reg;
        end
      endcase
    end
    // Read path: data stands for the one cycle after the strobe
    st_d.rd_data = REG_RESET;
    if (rd_strobe_in && selected) begin
      case (addr)
        ADDR_PORT_A: begin
          // Pins, not the latch, so a loaded output can read low
          st_d.rd_data = st_q.side_a_control_reg[BIT_ACCESS] ? pa_level
                                                             : st_q.port_a_direction;
        end
        ADDR_CTL_A: begin
          st_d.rd_data = ctl_a_view;
        end
        ADDR_PORT_B: begin
          st_d.rd_data = st_q.side_b_control_reg[BIT_ACCESS] ? pb_view
                                                             : st_q.port_b_direction;
        end
        ADDR_CTL_B: begin
          st_d.rd_data = ctl_b_view;
        end
        default: begin
          st_d.rd_data = REG_RESET;
        end
      endcase
    end
    // Pin drivers: port A and B enables follow direction, so input lines are released
    st_d.pa_out = st_q.port_a_out_latch;
    st_d.pa_oe  = st_q.port_a_direction;
    st_d.pb_out = st_q.port_b_out_latch;
    st_d.pb_oe  = st_q.port_b_direction;
    // Requests
    st_d.req_a  = dpa_req(flag_a1, flag_a2, st_q.side_a_control_reg);
    st_d.req_b  = dpa_req(flag_b1, flag_b2, st_q.side_b_control_reg);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_out        = st_q.rd_data;
  assign port_a_pins_out    = st_q.pa_out;
  assign port_a_pins_oe_out = st_q.pa_oe;
  assign port_b_pins_out    = st_q.pb_out;
  assign port_b_pins_oe_out = st_q.pb_oe;
  // Open drain: level is low whenever driven, enable carries the request
  assign side_a_req_n_out   = ~st_q.req_a;
  assign side_a_req_oe_out  = st_q.req_a;
  assign side_b_req_n_out   = ~st_q.req_b;
  assign side_b_req_oe_out  = st_q.req_b;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dpa_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_port_a_pins: assert property (
    rd_port_a |=> rd_data_out == $past(pa_level))
    else $error("port A data read did not return pin levels");

  a_port_b_mix: assert property (
    rd_port_b |=> rd_data_out == $past(pb_view))
    else $error("port B data read did not mix latch and pins");

  a_dir_select: assert property (
    rd_strobe_in && selected && addr == ADDR_PORT_A
      && !st_q.side_a_control_reg[BIT_ACCESS]
    |=> rd_data_out == $past(st_q.port_a_direction))
    else $error("direction register not read with access bit clear");

  a_ctl_read: assert property (
    rd_strobe_in && selected && addr == ADDR_CTL_B
    |=> rd_data_out == $past(ctl_b_view))
    else $error("control B read returned wrong value");

  a_flag_set: assert property (
    evt_a1 |=> flag_a1 ##1 side_a_req_oe_out == ($past(st_q.side_a_control_reg[BIT_L1_EN])
      || ($past(flag_a2) && $past(st_q.side_a_control_reg[BIT_L2_EN]))))
    else $error("side A line one edge did not set flag and request");

  a_flag_a_clear: assert property (
    rd_port_a && !evt_a1 && !evt_a2 |=> !flag_a1 && !flag_a2)
    else $error("port A data read did not clear side A flags");

  a_flag_b_clear: assert property (
    rd_port_b && !evt_b1 && !evt_b2 |=> !flag_b1 && !flag_b2)
    else $error("port B data read did not clear side B flags");

  a_ctl2_output: assert property (
    st_q.side_a_control_reg[BIT_L2_OUT] |-> !evt_a2)
    else $error("side A line two set a flag while an output");

  a_req_b_level: assert property (
    flag_b2 && st_q.side_b_control_reg[BIT_L2_EN] |=> side_b_req_oe_out && !side_b_req_n_out)
    else $error("side B request not asserted for enabled flag");

  a_drive_a: assert property (
    wr_strobe_in && selected && addr == ADDR_PORT_A
      && st_q.side_a_control_reg[BIT_ACCESS]
    |=> ##1 port_a_pins_out == $past(wr_data_in, 2))
    else $error("port A pins do not follow the written latch");

  a_b_hiz: assert property (
    wr_strobe_in && selected && addr == ADDR_PORT_B
      && !st_q.side_b_control_reg[BIT_ACCESS]
    |=> ##1 port_b_pins_oe_out == $past(wr_data_in, 2))
    else $error("port B enables do not follow the direction register");

  a_dir_a_oe: assert property (
    wr_strobe_in && selected && addr == ADDR_PORT_A
      && !st_q.side_a_control_reg[BIT_ACCESS]
    |=> ##1 port_a_pins_oe_out == $past(wr_data_in, 2))
    else $error("port A enables do not follow the direction register");

  a_ctl_write: assert property (
    wr_strobe_in && selected && addr == ADDR_CTL_A
    |=> st_q.side_a_control_reg == $past(wr_data_in[CTL_W-1:0]))
    else $error("control A write did not store the low bits");

  a_rd_idle: assert property (
    !(rd_strobe_in && selected) |=> rd_data_out == REG_RESET)
    else $error("read data shown without a selected read");

  a_line1_edge: assert property (
    evt_a1 |-> ctl_level[0] == st_q.side_a_control_reg[BIT_L1_EDGE])
    else $error("side A line one event on the wrong transition");

  a_line2_edge: assert property (
    evt_b2 |-> ctl_level[3] == st_q.side_b_control_reg[BIT_L2_EDGE])
    else $error("side B line two event on the wrong transition");

  a_flag_b_set: assert property (
    evt_b1 || evt_b2 |=> (flag_b1 || !$past(evt_b1)) && (flag_b2 || !$past(evt_b2)))
    else $error("side B edge did not set its flag");

  a_req_a_level: assert property (
    flag_a1 && st_q.side_a_control_reg[BIT_L1_EN] |=> side_a_req_oe_out && !side_a_req_n_out)
    else $error("side A request not asserted for enabled flag");

endmodule // dpa_adapter

`default_nettype wire

// File: logic/dpa_pkg.sv
// Shared constants, field positions and helper functions of the dual port adapter
`default_nettype none

package dpa_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned CTL_W       = 6;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [5:0]  CTL_RESET   = 6'h00;
  // Edges after reset before a synchronised control line is trusted
  localparam logic [2:0]  FLAG_SETTLE = 3'h5;

  // ----------------------------------------------------------------
  // Register locations, address = {reg_select_hi, reg_select_lo}
  // ----------------------------------------------------------------
  localparam logic [1:0]  ADDR_PORT_A = 2'h0;
  localparam logic [1:0]  ADDR_CTL_A  = 2'h1;
  localparam logic [1:0]  ADDR_PORT_B = 2'h2;
  localparam logic [1:0]  ADDR_CTL_B  = 2'h3;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_FLAG1   = 7;
  localparam int unsigned BIT_FLAG2   = 6;
  localparam int unsigned BIT_L2_OUT  = 5;
  localparam int unsigned BIT_L2_EDGE = 4;
  localparam int unsigned BIT_L2_EN   = 3;
  localparam int unsigned BIT_ACCESS  = 2;
  localparam int unsigned BIT_L1_EDGE = 1;
  localparam int unsigned BIT_L1_EN   = 0;

  // Control register as software sees it: two flags above the stored bits
  function automatic logic [7:0] dpa_ctl_view(input logic       flag1,
                                              input logic       flag2,
                                              input logic [5:0] ctl);
    dpa_ctl_view = {flag1, flag2, ctl};
  endfunction

  // Request is active when either flag meets its enable
  function automatic logic dpa_req(input logic       flag1,
                                   input logic       flag2,
                                   input logic [5:0] ctl);
    dpa_req = (flag1 & ctl[BIT_L1_EN]) | (flag2 & ctl[BIT_L2_EN]);
  endfunction

endpackage

`default_nettype wire

// File: logic/dpa_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module dpa_pin_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] level_out
);
  import dpa_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } dpa_sync_state_type;

  dpa_sync_state_type st_q;
  dpa_sync_state_type st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = raw_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Accept a new level only where the second and third stages agree
    st_d.level = (st_q.s2 & st_q.s3) | (st_q.level & (st_q.s2 | st_q.s3));
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;

endmodule // dpa_pin_sync

`default_nettype wire

// File: logic/dpa_side_flags.sv
// Edge detection and interrupt flags of one adapter side
`default_nettype none

module dpa_side_flags (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic line1_in,
  input  wire logic line2_in,
  input  wire logic edge1_rise_in,
  input  wire logic edge2_rise_in,
  input  wire logic line2_is_input_in,
  input  wire logic clear_in,
  output logic      evt1_out,
  output logic      evt2_out,
  output logic      flag1_out,
  output logic      flag2_out
);
  import dpa_pkg::*;

  typedef struct packed {
    logic [2:0] warm;
    logic prev1;
    logic prev2;
    logic flag1;
    logic flag2;
  } dpa_flag_state_type;

  dpa_flag_state_type st_q;
  dpa_flag_state_type st_d;
  logic               evt1;
  logic               evt2;
  logic               settled;

  always_comb begin
    st_d = st_q;
    // Trust samples only once the synchroniser passes real pin levels, not its reset zero
    settled = (st_q.warm == FLAG_SETTLE);
    evt1 = settled & (edge1_rise_in ? (line1_in & ~st_q.prev1)
                                    : (~line1_in & st_q.prev1));
    evt2 = settled & line2_is_input_in
         & (edge2_rise_in ? (line2_in & ~st_q.prev2) : (~line2_in & st_q.prev2));
    st_d.warm   = settled ? st_q.warm : st_q.warm + 3'h1;
    st_d.prev1  = line1_in;
    st_d.prev2  = line2_in;
    // A new edge wins over a clearing read in the same cycle
    st_d.flag1  = evt1 | (st_q.flag1 & ~clear_in);
    st_d.flag2  = evt2 | (st_q.flag2 & ~clear_in);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign evt1_out  = evt1;
  assign evt2_out  = evt2;
  assign flag1_out = st_q.flag1;
  assign flag2_out = st_q.flag2;

endmodule // dpa_side_flags

`default_nettype wire

// File: bench/dpa_periph_model.sv
// Peripheral side model: port pins, loads and the shared request lines
`default_nettype none

module dpa_periph_model (
  input  wire logic [7:0] a_drive_in,
  input  wire logic [7:0] a_oe_in,
  input  wire logic [7:0] a_ext_in,
  input  wire logic [7:0] a_load_in,
  input  wire logic [7:0] b_drive_in,
  input  wire logic [7:0] b_oe_in,
  input  wire logic [7:0] b_ext_in,
  input  wire logic [7:0] b_load_in,
  input  wire logic       a_req_n_in,
  input  wire logic       a_req_oe_in,
  input  wire logic       b_req_n_in,
  input  wire logic       b_req_oe_in,
  output logic      [7:0] a_pins_out,
  output logic      [7:0] b_pins_out,
  output logic            a_req_level_out,
  output logic            b_req_level_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Pins: a heavy load drags a driven high line low
  // ----------------------------------------------------------------
  assign a_pins_out = (a_oe_in & a_drive_in & ~a_load_in) | (~a_oe_in & a_ext_in);
  assign b_pins_out = (b_oe_in & b_drive_in & ~b_load_in) | (~b_oe_in & b_ext_in);

  // ----------------------------------------------------------------
  // Request lines: pulled up, low only while a driver sinks
  // ----------------------------------------------------------------
  assign a_req_level_out = (a_req_oe_in & ~a_req_n_in) ? 1'h0 : 1'h1;
  assign b_req_level_out = (b_req_oe_in & ~b_req_n_in) ? 1'h0 : 1'h1;
endmodule // dpa_periph_model

`default_nettype wire

// File: bench/test_dual_port_adapter_read_irq.sv
// Self-checking bench of the dual port adapter with a peripheral model
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", what, exp, got); end end

module test_dual_port_adapter_read_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import dpa_pkg::*;

  logic       clock_in, rst_in, sel1, sel2, sel3, rs_hi, rs_lo, wr_stb, rd_stb;
  logic [7:0] wr_data, rd_data, got, ctl;
  logic [7:0] a_out, a_oe, b_out, b_oe, a_pins, b_pins, a_ext, b_ext, a_load, b_load;
  logic [7:0] dir_a, lat_a, ext_a, ld_a, dir_b, lat_b, ext_b, ld_b;
  logic [3:0] lines, cfg;
  logic [1:0] caddr, paddr;
  logic       a_req_n, a_req_oe, b_req_n, b_req_oe, a_req, b_req;
  int         err_total, num_checks;

  dpa_adapter dpa_adapter_inst (
    .clock_in(clock_in), .rst_in(rst_in), .select_high_first_in(sel1),
    .select_high_second_in(sel2), .select_low_in(sel3), .reg_select_hi_in(rs_hi),
    .reg_select_lo_in(rs_lo), .wr_data_in(wr_data), .wr_strobe_in(wr_stb),
    .rd_strobe_in(rd_stb), .rd_data_out(rd_data), .port_a_pins_in(a_pins),
    .port_a_pins_out(a_out), .port_a_pins_oe_out(a_oe), .port_b_pins_in(b_pins),
    .port_b_pins_out(b_out), .port_b_pins_oe_out(b_oe), .side_a_irq_input_in(lines[0]),
    .side_a_ctl_line_in(lines[1]), .side_b_irq_input_in(lines[2]),
    .side_b_ctl_line_in(lines[3]), .side_a_req_n_out(a_req_n), .side_a_req_oe_out(a_req_oe),
    .side_b_req_n_out(b_req_n), .side_b_req_oe_out(b_req_oe));

  dpa_periph_model dpa_periph_model_inst (
    .a_drive_in(a_out), .a_oe_in(a_oe), .a_ext_in(a_ext), .a_load_in(a_load),
    .b_drive_in(b_out), .b_oe_in(b_oe), .b_ext_in(b_ext), .b_load_in(b_load),
    .a_req_n_in(a_req_n), .a_req_oe_in(a_req_oe), .b_req_n_in(b_req_n),
    .b_req_oe_in(b_req_oe), .a_pins_out(a_pins), .b_pins_out(b_pins),
    .a_req_level_out(a_req), .b_req_level_out(b_req));

  // ----------------------------------------------------------------
  // Clock, bus tasks and expectations
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'h0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic bus_wr(input logic [1:0] addr, input logic [7:0] data,
                        input logic [2:0] sel = 3'h6);
    @(posedge clock_in);
    {sel1, sel2, sel3} <= sel;
    {rs_hi, rs_lo} <= addr;
    wr_data <= data;
    wr_stb <= 1'h1;
    @(posedge clock_in);
    wr_stb <= 1'h0;
    {sel1, sel2, sel3} <= 3'h6;
  endtask

  task automatic bus_rd(input logic [1:0] addr, output logic [7:0] data);
    @(posedge clock_in);
    {rs_hi, rs_lo} <= addr;
    rd_stb <= 1'h1;
    @(posedge clock_in);
    rd_stb <= 1'h0;
    #1 data = rd_data;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  function automatic logic [7:0] exp_a(input logic [7:0] dir, lat, ext, load);
    return (dir & lat & ~load) | (~dir & ext);
  endfunction

  function automatic logic [7:0] exp_b(input logic [7:0] dir, lat, ext);
    return (dir & lat) | (~dir & ext);
  endfunction

  task automatic complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    {sel1, sel2, sel3} = 3'h6;
    {rs_hi, rs_lo, wr_stb, rd_stb} = 4'h0;
    wr_data = 8'h00;
    {a_ext, b_ext, a_load, b_load} = 32'h0;
    lines = 4'h0;
    rst_in = 1'h1;
    void'($urandom(39));
    wait_n(2);
    rst_in <= 1'h0;
    #1 `CHK("a_oe", 8'h00, a_oe)
    `CHK("b_oe", 8'h00, b_oe)
    `CHK("a_req_oe", 1'h0, a_req_oe)
    for (int i = 0; i < 4; i++) begin
      bus_rd(2'(i), got);
      `CHK("reset reg", 8'h00, got)
    end
    // Writes with each select line wrong in turn (3'h2, 3'h4, 3'h7) are dropped; flag bits are not writable
    foreach (cfg[i]) begin
      bus_wr(ADDR_CTL_A, 8'h3F, (i == 0) ? 3'h2 : (i == 1) ? 3'h4 : 3'h7);
      bus_rd(ADDR_CTL_A, got);
      `CHK("ctl unselected", 8'h00, got)
    end
    bus_wr(ADDR_CTL_A, 8'hC4);
    bus_rd(ADDR_CTL_A, got);
    `CHK("ctl flags", 8'h04, got)

    // Random port traffic with corner patterns first
    for (int n = 0; n < 12; n++) begin
      {dir_a, lat_a, ext_a, ld_a} = $urandom;
      {dir_b, lat_b, ext_b, ld_b} = $urandom;
      if (n == 0) {dir_a, lat_a, ld_a, dir_b, lat_b, ld_b} = {8'hFF, 8'hFF, 8'h55, 8'hFF,
                                                              8'hFF, 8'hAA};
      if (n == 1) {dir_a, dir_b} = 16'h0;
      a_ext <= ext_a;
      b_ext <= ext_b;
      a_load <= ld_a;
      b_load <= ld_b;
      bus_wr(ADDR_CTL_A, 8'h00);
      bus_wr(ADDR_PORT_A, dir_a);
      bus_wr(ADDR_CTL_A, 8'h04);
      bus_wr(ADDR_PORT_A, lat_a);
      bus_wr(ADDR_CTL_B, 8'h00);
      bus_wr(ADDR_PORT_B, dir_b);
      bus_wr(ADDR_CTL_B, 8'h04);
      bus_wr(ADDR_PORT_B, lat_b);
      wait_n(6);
      `CHK("a_oe", dir_a, a_oe)
      `CHK("a_out", lat_a, a_out)
      `CHK("b_oe", dir_b, b_oe)
      `CHK("b_out", lat_b, b_out)
      bus_rd(ADDR_PORT_A, got);
      `CHK("port a read", exp_a(dir_a, lat_a, ext_a, ld_a), got)
      bus_rd(ADDR_PORT_B, got);
      `CHK("port b read", exp_b(dir_b, lat_b, ext_b), got)
      bus_wr(ADDR_CTL_B, 8'h00);
      bus_rd(ADDR_PORT_B, got);
      `CHK("dir b read", dir_b, got)
    end

    // Every side, line, polarity and enable: set, request, clear, wrong edge
    for (int k = 0; k < 16; k++) begin
      cfg = 4'(k);
      ctl = 8'h04 | (cfg[2] ? {3'h0, cfg[1], cfg[0], 3'h0} : {6'h00, cfg[1], cfg[0]});
      caddr = cfg[3] ? ADDR_CTL_B : ADDR_CTL_A;
      paddr = cfg[3] ? ADDR_PORT_B : ADDR_PORT_A;
      lines[cfg[3:2]] <= ~cfg[1];
      wait_n(6);
      bus_wr(caddr, ctl);
      bus_rd(paddr, got);
      @(posedge clock_in);
      lines[cfg[3:2]] <= cfg[1];
      wait_n(8);
      bus_rd(caddr, got);
      `CHK("flag set", {~cfg[2], cfg[2], ctl[5:0]}, got)
      `CHK("req oe", cfg[0], cfg[3] ? b_req_oe : a_req_oe)
      `CHK("req level", ~cfg[0], cfg[3] ? b_req : a_req)
      bus_rd(paddr, got);
      wait_n(3);
      bus_rd(caddr, got);
      `CHK("flag clear", ctl, got)
      `CHK("req released", 1'h1, cfg[3] ? b_req : a_req)
      @(posedge clock_in);
      lines[cfg[3:2]] <= ~cfg[1];
      wait_n(8);
      bus_rd(caddr, got);
      `CHK("wrong edge", ctl, got)
    end
    // Line two set as an output takes no edges
    bus_wr(ADDR_CTL_A, 8'h3C);
    @(posedge clock_in);
    lines[1] <= 1'h1;
    wait_n(8);
    bus_rd(ADDR_CTL_A, got);
    `CHK("line2 output", 8'h3C, got)
    // Reset in mid run clears the port A latch and control register A
    bus_wr(ADDR_PORT_A, 8'hA5);
    wait_n(2);
    `CHK("a_out", 8'hA5, a_out)
    rst_in <= 1'h1;
    wait_n(2);
    rst_in <= 1'h0;
    wait_n(1);
    `CHK("mid reset a_out", 8'h00, a_out)
    bus_rd(ADDR_CTL_A, got);
    `CHK("mid reset ctl", 8'h00, got)
    complete_run();
  end
endmodule // test_dual_port_adapter_read_irq

`default_nettype wire
